// *** core/sdsp_pkg.sv ***
// shared constants and types for the sigma-delta serial port block
// assumes a single 100 MHz master clock domain and a plain register port
package sdsp_pkg;
    // register offsets (byte addresses)
    localparam logic [7:0] CTRL_OFS   = 8'h00;
    localparam logic [7:0] STATUS_OFS = 8'h04;
    localparam logic [7:0] MASK_OFS   = 8'h08;
    localparam logic [7:0] WRWORD_OFS = 8'h0c;
    localparam logic [7:0] STATE_OFS  = 8'h10;
    // field positions
    localparam int CTRL_LOWPWR_BIT = 0;
    localparam int EV_FRAME_BIT    = 0;
    localparam int EV_WRITE_BIT    = 1;
    localparam int EV_SYNC_BIT     = 2;
    localparam int EV_OVR_BIT      = 3;
    localparam int EV_W            = 4;
    // reset values
    localparam logic [31:0] CTRL_RST = 32'h0000_0000;
    localparam logic [3:0]  MASK_RST = 4'h0;
    // timing counts: half periods in master cycles, frame and write lengths in bits
    localparam logic [1:0] HALF_NORMAL = 2'h1; // serial clock = master / 2
    localparam logic [1:0] HALF_LOWPWR = 2'h2; // serial clock = master / 4
    localparam logic [8:0] FRAME_BITS  = 9'h020; // serial bits per frame
    localparam logic [4:0] WRITE_LAST  = 5'h1f; // index of last write bit
    // decimation codes
    localparam logic [1:0] DEC_64  = 2'h0;
    localparam logic [1:0] DEC_128 = 2'h1;
    localparam logic [1:0] DEC_256 = 2'h2;

    typedef struct packed {
        logic [15:0] addr; // device and register address word
        logic [15:0] data; // value word
    } sdsp_wr_word_t;

    typedef enum logic [2:0] {
        RX_IDLE  = 3'b001,
        RX_SHIFT = 3'b010,
        RX_WAIT  = 3'b100
    } sdsp_rx_state_t;
endpackage

// *** core/sdsp_core.sv ***
// serial port, sync, power-down and strap logic of a sigma-delta converter
// assumes i_clk is the master clock; pins are asynchronous and are synchronised here
//
// The strobed register port and the register offsets were chosen for this implementation.
`timescale 1ns/1ns
// Operation
// - serial output clock is derived from, and equals, the modulator clock
// - output frame marker stays low for 32 serial clock periods
// - result and status bits change on rising edge, valid at falling edge
// - input frame marker sampled on falling edges; first bit next falling edge
// - a write is 32 bits: address word then data word
// - falling edge on sync input restarts the decimation filter
// - while reset/power-down input is low, everything is held in reset; here the pin synchronisers are not reset and the strap is still tracked
// - strap high selects 64, floating 128, grounded 256 decimation
// - overrange output high while input nears the modulator limit
// - modulator clock is master divided by two, or four in low power
module sdsp_core (
    input  wire logic                   i_clk,
    input  wire logic                   i_sys_rst,
    input  wire logic [7:0]             i_reg_addr,
    input  wire logic [31:0]            i_reg_wdata,
    input  wire logic                   i_reg_wr,
    input  wire logic                   i_reg_rd,
    output logic [31:0]                 o_reg_rdata,
    output logic                        o_irq,
    input  wire logic [23:0]            i_sample,
    input  wire logic                   i_overrange_level,
    input  wire logic                   i_input_frame_marker_n,
    input  wire logic                   i_serial_write_line,
    input  wire logic                   i_sync_n,
    input  wire logic                   i_reset_powerdown_input_n,
    input  wire logic                   i_strap_high,
    input  wire logic                   i_strap_low,
    output logic                        o_internal_modulator_clock,
    output logic                        o_output_frame_marker_n,
    output logic                        o_serial_result_line,
    output logic                        o_filter_restart,
    output logic                        o_overrange,
    output logic                        o_powered_down,
    output logic                        o_wr_valid,
    output sdsp_pkg::sdsp_wr_word_t     o_wr_word
);
    // decimation code to ratio, used by framing and readback
    function automatic logic [8:0] dec_ratio(input logic [1:0] code);
        case (code)
            sdsp_pkg::DEC_64:  dec_ratio = 9'h040;
            sdsp_pkg::DEC_128: dec_ratio = 9'h080;
            // codes outside the three known ones fall back to the widest ratio
            default:           dec_ratio = 9'h100;
        endcase
    endfunction

    // two-flop synchronisers for all pins; first stage feeds only the second
    // no reset here: the strap must be seen while the block is held in reset,
    // and the power-down pin must be seen to leave power-down
    logic [5:0] pin_s1_reg;
    logic [5:0] pin_s2_reg;
    logic       sync_s3_reg;
    always_ff @(posedge i_clk) begin
        pin_s1_reg  <= {i_input_frame_marker_n, i_serial_write_line, i_sync_n,
                        i_reset_powerdown_input_n, i_strap_high, i_strap_low};
        pin_s2_reg  <= pin_s1_reg;
        sync_s3_reg <= pin_s2_reg[3];
    end
    logic fsi_n_s, sdi_s, pd_n_s, strap_hi_s, strap_lo_s;
    assign fsi_n_s    = pin_s2_reg[5];
    assign sdi_s      = pin_s2_reg[4];
    assign pd_n_s     = pin_s2_reg[2];
    assign strap_hi_s = pin_s2_reg[1];
    assign strap_lo_s = pin_s2_reg[0];

    // power-down folds into the block reset
    // the pin is two flops deep, so power-down starts two cycles after it
    logic rst;
    assign rst = i_sys_rst | ~pd_n_s;
    assign o_powered_down = ~pd_n_s;

    // strap tracked while in reset, frozen at release
    logic [1:0] dec_reg, dec_next;
    always_comb begin
        dec_next = dec_reg;
        if (rst) begin
            if (strap_hi_s && !strap_lo_s) dec_next = sdsp_pkg::DEC_64;
            else if (!strap_hi_s && strap_lo_s) dec_next = sdsp_pkg::DEC_256;
            // both comparators set, or neither, reads as a floating pin
            else dec_next = sdsp_pkg::DEC_128;
        end
    end
    always_ff @(posedge i_clk) begin
        dec_reg <= dec_next;
    end

    // register file state
    // only control, status and mask are writable; the rest read back state
    logic [31:0]            ctrl_reg, ctrl_next;
    logic [3:0]             status_reg, status_next;
    logic [3:0]             mask_reg, mask_next;
    logic [31:0]            rdata_reg, rdata_next;
    logic [3:0]             ev;
    sdsp_pkg::sdsp_wr_word_t last_wr_reg;
    logic                   low_power;
    assign low_power = ctrl_reg[sdsp_pkg::CTRL_LOWPWR_BIT];

    // serial clock divider and output framing
    // the serial clock is a register toggled on master edges, so rise and fall
    // are known one cycle early and data can be launched with the clock edge
    logic [1:0]  div_reg, div_next;
    logic        sco_reg, sco_next;
    logic [8:0]  pos_reg, pos_next;
    logic [31:0] shift_reg, shift_next;
    logic        fso_n_reg, fso_n_next;
    logic        sdo_reg, sdo_next;
    logic        ovr_reg, ovr_next;
    logic        restart_reg, restart_next;
    logic        toggle, rise, fall;
    logic [1:0]  half;
    logic [8:0]  pos_inc;
    logic        sync_fall;
    assign half      = low_power ? sdsp_pkg::HALF_LOWPWR : sdsp_pkg::HALF_NORMAL;
    assign toggle    = (div_reg >= half - 2'h1);
    assign rise      = toggle & ~sco_reg;
    assign fall      = toggle & sco_reg;
    assign sync_fall = sync_s3_reg & ~pin_s2_reg[3];
    assign pos_inc   = pos_reg + 9'h001;
    always_comb begin
        div_next     = toggle ? 2'h0 : div_reg + 2'h1;
        sco_next     = toggle ? ~sco_reg : sco_reg;
        pos_next     = pos_reg;
        shift_next   = shift_reg;
        fso_n_next   = fso_n_reg;
        sdo_next     = sdo_reg;
        ovr_next     = i_overrange_level;
        restart_next = sync_fall;
        // a sync fall outranks a serial clock rise in the same cycle
        if (sync_fall) begin
            // filter restarts: drop the frame and begin a fresh decimation period
            pos_next   = dec_ratio(dec_reg) - 9'h001;
            fso_n_next = 1'b1;
            sdo_next   = 1'b0;
        end else if (rise) begin
            pos_next = (pos_reg >= dec_ratio(dec_reg) - 9'h001) ? 9'h000 : pos_inc;
            if (pos_next == 9'h000) begin
                // status byte: overrange, decimation code, power mode
                shift_next = {i_sample, i_overrange_level, dec_reg, low_power, 4'h0};
                sdo_next   = i_sample[23];
                fso_n_next = 1'b0;
            end else if (pos_next < sdsp_pkg::FRAME_BITS) begin
                shift_next = {shift_reg[30:0], 1'b0};
                sdo_next   = shift_reg[30];
            end else begin
                fso_n_next = 1'b1;
                sdo_next   = 1'b0;
            end
        end
    end
    always_ff @(posedge i_clk) begin
        if (rst) begin
            div_reg     <= 2'h0;
            sco_reg     <= 1'b0;
            pos_reg     <= 9'h0ff;
            shift_reg   <= 32'h0000_0000;
            fso_n_reg   <= 1'b1;
            sdo_reg     <= 1'b0;
            ovr_reg     <= 1'b0;
            restart_reg <= 1'b0;
        end else begin
            div_reg     <= div_next;
            sco_reg     <= sco_next;
            pos_reg     <= pos_next;
            shift_reg   <= shift_next;
            fso_n_reg   <= fso_n_next;
            sdo_reg     <= sdo_next;
            ovr_reg     <= ovr_next;
            restart_reg <= restart_next;
        end
    end
    // pins come straight from flops, no logic after the registers
    assign o_internal_modulator_clock = sco_reg;
    assign o_output_frame_marker_n    = fso_n_reg;
    assign o_serial_result_line       = sdo_reg;
    assign o_overrange                = ovr_reg;
    assign o_filter_restart           = restart_reg;

    // write receiver; falling strobe delayed two cycles to match the pin synchronisers
    // so the marker and data seen are those that stood at the serial fall;
    // the host may change them as soon as that fall has passed
    sdsp_pkg::sdsp_rx_state_t rx_reg, rx_next;
    logic [1:0]  fall_d_reg;
    logic [4:0]  bit_reg, bit_next;
    logic [31:0] rx_sh_reg, rx_sh_next;
    logic        wr_valid_reg, wr_valid_next;
    sdsp_pkg::sdsp_wr_word_t wr_word_reg, wr_word_next;
    always_comb begin
        rx_next       = rx_reg;
        bit_next      = bit_reg;
        rx_sh_next    = rx_sh_reg;
        wr_valid_next = 1'b0;
        wr_word_next  = wr_word_reg;
        if (fall_d_reg[1]) begin
            case (rx_reg)
                sdsp_pkg::RX_IDLE: begin
                    if (!fsi_n_s) begin
                        rx_next  = sdsp_pkg::RX_SHIFT;
                        bit_next = 5'h00;
                    end
                end
                sdsp_pkg::RX_SHIFT: begin
                    rx_sh_next = {rx_sh_reg[30:0], sdi_s};
                    bit_next   = bit_reg + 5'h01;
                    if (bit_reg == sdsp_pkg::WRITE_LAST) begin
                        wr_valid_next = 1'b1;
                        wr_word_next  = {rx_sh_reg[30:0], sdi_s};
                        rx_next       = sdsp_pkg::RX_WAIT;
                    end
                end
                sdsp_pkg::RX_WAIT: begin
                    // marker still low after 32 bits is not a new write
                    if (fsi_n_s) rx_next = sdsp_pkg::RX_IDLE;
                end
                default: rx_next = sdsp_pkg::RX_IDLE;
            endcase
        end
    end
    // the fall pipeline is cleared too, so no stale strobe survives power-down
    always_ff @(posedge i_clk) begin
        if (rst) begin
            rx_reg       <= sdsp_pkg::RX_IDLE;
            fall_d_reg   <= 2'h0;
            bit_reg      <= 5'h00;
            rx_sh_reg    <= 32'h0000_0000;
            wr_valid_reg <= 1'b0;
            wr_word_reg  <= '0;
        end else begin
            rx_reg       <= rx_next;
            fall_d_reg   <= {fall_d_reg[0], fall};
            bit_reg      <= bit_next;
            rx_sh_reg    <= rx_sh_next;
            wr_valid_reg <= wr_valid_next;
            wr_word_reg  <= wr_word_next;
        end
    end
    // the word holds until the next complete write
    assign o_wr_valid = wr_valid_reg;
    assign o_wr_word  = wr_word_reg;

    // events: frame start, write received, filter restart, overrange rise
    // each event is a one-cycle strobe; status keeps it until software clears it
    always_comb begin
        ev = 4'h0;
        ev[sdsp_pkg::EV_FRAME_BIT] = fso_n_reg & ~fso_n_next;
        ev[sdsp_pkg::EV_WRITE_BIT] = wr_valid_reg;
        ev[sdsp_pkg::EV_SYNC_BIT]  = restart_reg;
        ev[sdsp_pkg::EV_OVR_BIT]   = ~ovr_reg & ovr_next;
    end

    // register port; write-one-to-clear, a same-cycle event wins
    // read data stand only in the cycle after the read strobe, zero otherwise
    always_comb begin
        ctrl_next   = ctrl_reg;
        mask_next   = mask_reg;
        status_next = status_reg;
        rdata_next  = 32'h0000_0000;
        if (i_reg_wr) begin
            case (i_reg_addr)
                sdsp_pkg::CTRL_OFS:   ctrl_next = {31'h0, i_reg_wdata[sdsp_pkg::CTRL_LOWPWR_BIT]};
                sdsp_pkg::STATUS_OFS: status_next = status_reg & ~i_reg_wdata[3:0];
                sdsp_pkg::MASK_OFS:   mask_next = i_reg_wdata[3:0];
                default: ;
            endcase
        end
        status_next = status_next | ev;
        if (i_reg_rd) begin
            case (i_reg_addr)
                sdsp_pkg::CTRL_OFS:   rdata_next = ctrl_reg;
                sdsp_pkg::STATUS_OFS: rdata_next = {28'h0, status_reg};
                sdsp_pkg::MASK_OFS:   rdata_next = {28'h0, mask_reg};
                sdsp_pkg::WRWORD_OFS: rdata_next = last_wr_reg;
                sdsp_pkg::STATE_OFS:  rdata_next = {19'h0, ovr_reg, dec_ratio(dec_reg), 1'b0, dec_reg};
                default:              rdata_next = 32'h0000_0000;
            endcase
        end
    end
    always_ff @(posedge i_clk) begin
        if (rst) begin
            ctrl_reg    <= sdsp_pkg::CTRL_RST;
            mask_reg    <= sdsp_pkg::MASK_RST;
            status_reg  <= 4'h0;
            rdata_reg   <= 32'h0000_0000;
            last_wr_reg <= '0;
        end else begin
            ctrl_reg    <= ctrl_next;
            mask_reg    <= mask_next;
            status_reg  <= status_next;
            rdata_reg   <= rdata_next;
            last_wr_reg <= wr_valid_reg ? wr_word_reg : last_wr_reg;
        end
    end
    assign o_reg_rdata = rdata_reg;
    // level interrupt straight from the registers, so a clear shows next cycle
    assign o_irq       = |(status_reg & mask_reg);
endmodule

// *** dv/sdsp_core_properties.sv ***
// assertion checker for the sigma-delta serial port core
// sees only core ports; bound into every sdsp_core at the foot
`timescale 1ns/1ns
module sdsp_core_checker (
    input wire logic                    i_clk,
    input wire logic                    i_sys_rst,
    input wire logic                    i_overrange_level,
    input wire logic                    i_sync_n,
    input wire logic                    i_reset_powerdown_input_n,
    input wire logic                    o_internal_modulator_clock,
    input wire logic                    o_output_frame_marker_n,
    input wire logic                    o_serial_result_line,
    input wire logic                    o_filter_restart,
    input wire logic                    o_overrange,
    input wire logic                    o_powered_down,
    input wire logic                    o_wr_valid,
    input wire sdsp_pkg::sdsp_wr_word_t o_wr_word
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_sys_rst || o_powered_down);
    logic [5:0] n_rise;
    // serial clock rises seen inside the current output frame
    always_ff @(posedge i_clk) begin
        if (i_sys_rst || o_powered_down) begin
            n_rise <= 6'h00;
        end else if ($fell(o_output_frame_marker_n)) begin
            n_rise <= 6'h01;
        end else if ($rose(o_internal_modulator_clock) && !o_output_frame_marker_n) begin
            n_rise <= n_rise + 6'h01;
        end
    end
    property p_clk_half;
        $rose(o_internal_modulator_clock) |-> ##[1:2] !o_internal_modulator_clock;
    endproperty
    a_clk_half: assert property (p_clk_half) else $error("serial clock high too long");
    property p_frame_len;
        $rose(o_output_frame_marker_n) && !o_filter_restart |-> n_rise == 6'h20;
    endproperty
    a_frame_len: assert property (p_frame_len) else $error("frame marker width wrong");
    property p_bit_edge;
        $changed(o_serial_result_line) && !o_output_frame_marker_n |-> $rose(o_internal_modulator_clock);
    endproperty
    a_bit_edge: assert property (p_bit_edge) else $error("result bit moved off a rising edge");
    property p_sync;
        $fell(i_sync_n) |-> ##[2:5] o_filter_restart;
    endproperty
    a_sync: assert property (p_sync) else $error("no filter restart after sync");
    property p_pdown;
        disable iff (i_sys_rst)
        !i_reset_powerdown_input_n [*5] |-> o_powered_down && o_output_frame_marker_n && !o_wr_valid;
    endproperty
    a_pdown: assert property (p_pdown) else $error("power-down not held");
    property p_ovr;
        $changed(i_overrange_level) |=> $changed(o_overrange);
    endproperty
    a_ovr: assert property (p_ovr) else $error("overrange output lags");
    property p_wr_pulse;
        o_wr_valid |=> !o_wr_valid;
    endproperty
    a_wr_pulse: assert property (p_wr_pulse) else $error("write valid not a pulse");
    property p_wr_word;
        $changed(o_wr_word) |-> o_wr_valid;
    endproperty
    a_wr_word: assert property (p_wr_word) else $error("write word moved without valid");
endmodule

bind sdsp_core sdsp_core_checker u_chk (
    .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_overrange_level(i_overrange_level), .i_sync_n(i_sync_n),
    .i_reset_powerdown_input_n(i_reset_powerdown_input_n),
    .o_internal_modulator_clock(o_internal_modulator_clock), .o_output_frame_marker_n(o_output_frame_marker_n),
    .o_serial_result_line(o_serial_result_line), .o_filter_restart(o_filter_restart),
    .o_overrange(o_overrange), .o_powered_down(o_powered_down), .o_wr_valid(o_wr_valid), .o_wr_word(o_wr_word)
);

// *** dv/sdsp_host_model.sv ***
// host side of the serial port: collects result frames, sends register writes
// assumes it samples the core's outputs at master clock rising edges
`timescale 1ns/1ns
module sdsp_host_model (
    input  wire logic  i_clk,
    input  wire logic  i_sclk,
    input  wire logic  i_fso_n,
    input  wire logic  i_sdo,
    output logic       o_fsi_n,
    output logic       o_sdi,
    output logic       o_err,
    output logic [31:0] o_rx_word
);
    logic sclk_q;
    initial begin
        o_fsi_n = 1'b1;
        o_sdi   = 1'b0;
        o_err   = 1'b0;
    end
    // shift in result bits at serial clock falls inside the frame
    always @(posedge i_clk) begin
        sclk_q <= i_sclk;
        if (sclk_q && !i_sclk && !i_fso_n) o_rx_word <= {o_rx_word[30:0], i_sdo};
    end
    // bounded wait for the next serial clock fall
    task automatic wait_fall();
        logic p;
        int   k;
        p = i_sclk;
        for (k = 0; k < 16; k++) begin
            @(posedge i_clk);
            if (p && !i_sclk) break;
            p = i_sclk;
        end
        if (k >= 16) o_err = 1'b1;
    endtask
    // marker low for 32 serial periods, bits changed just after each fall
    task automatic send(input logic [31:0] w);
        int i;
        wait_fall();
        o_fsi_n <= 1'b0;
        for (i = 0; i < 33; i++) begin
            wait_fall();
            if (i < 32) o_sdi <= w[31 - i];
            else o_sdi <= ~o_sdi; // released line must not keep the last bit
            if (i == 31) o_fsi_n <= 1'b1;
        end
    endtask
endmodule

// *** dv/sdsp_core_test.sv ***
// self-checking bench for the sigma-delta serial port core
// drives pins and register port at rising edges; host model is the far side
`timescale 1ns/1ns
module sdsp_core_test;
    logic        clk, rst, wr, rd, ovr_lvl, sync_n, pd_n, s_hi, s_lo, irq, sclk, fso_n, serial_result_line;
    logic        fsi_n, serial_write_line, restart, ovr, pdown, wr_valid, host_err;
    logic [7:0]  addr;
    logic [31:0] wdata, rdata, v, rx_word;
    logic [23:0] smp;
    logic [4:0]  row;
    sdsp_pkg::sdsp_wr_word_t wr_word;
    int          n_fail, n_compared, r;
    time         t0;
    // each row: strap high, strap low, overrange level, expected decimation code
    localparam logic [4:0] ROWS [4] = '{5'h10, 5'h0e, 5'h05, 5'h19};

    sdsp_core dut (
        .i_clk(clk), .i_sys_rst(rst), .i_reg_addr(addr), .i_reg_wdata(wdata), .i_reg_wr(wr), .i_reg_rd(rd),
        .o_reg_rdata(rdata), .o_irq(irq), .i_sample(smp), .i_overrange_level(ovr_lvl),
        .i_input_frame_marker_n(fsi_n), .i_serial_write_line(serial_write_line), .i_sync_n(sync_n),
        .i_reset_powerdown_input_n(pd_n), .i_strap_high(s_hi), .i_strap_low(s_lo),
        .o_internal_modulator_clock(sclk), .o_output_frame_marker_n(fso_n), .o_serial_result_line(serial_result_line),
        .o_filter_restart(restart), .o_overrange(ovr), .o_powered_down(pdown), .o_wr_valid(wr_valid),
        .o_wr_word(wr_word)
    );
    sdsp_host_model host (
        .i_clk(clk), .i_sclk(sclk), .i_fso_n(fso_n), .i_sdo(serial_result_line), .o_fsi_n(fsi_n), .o_sdi(serial_write_line),
        .o_err(host_err), .o_rx_word(rx_word)
    );

    // 100 MHz master clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic tally_and_finish();
        $display("compared %0d, failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    function automatic logic pick(input int w);
        case (w)
            0: return fso_n;
            1: return sclk;
            2: return wr_valid;
            default: return restart;
        endcase
    endfunction
    // bounded wait; running out ends the run
    task automatic wait_on(input int w, input logic lvl, input int lim);
        int k;
        for (k = 0; k < lim && pick(w) !== lvl; k++) @(posedge clk);
        if (k >= lim) begin
            n_fail++;
            $display("mismatch at %0t: wait timed out", $time);
            tally_and_finish();
        end
    endtask
    task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(posedge clk);
        d = rdata;
    endtask

    initial begin
        n_fail = 0;
        n_compared = 0;
        {rst, wr, rd, ovr_lvl, s_hi, s_lo, sync_n, pd_n} = 8'h83;
        addr = 8'h00;
        wdata = 32'h0;
        smp = 24'h0;
        // strap decode, frame spacing and frame word, one reset per row
        for (r = 0; r < 4; r++) begin
            row = ROWS[r];
            @(posedge clk);
            {s_hi, s_lo, ovr_lvl} <= row[4:2];
            smp <= {19'h2b3c5, row};
            rst <= 1'b1;
            repeat (5) @(posedge clk);
            rst <= 1'b0;
            wait_on(0, 1'b0, 600);
            t0 = $time;
            wait_on(0, 1'b1, 200);
            wait_on(0, 1'b0, 1100);
            chk(32'($time - t0), 32'(20 * (64 << row[1:0])));
            wait_on(0, 1'b1, 200);
            chk(rx_word, {smp, row[2], row[1:0], 1'b0, 4'h0});
            $display("row %0d done", r);
        end
        // serial write, write event interrupt, masking, clearing, unmapped read
        reg_wr(sdsp_pkg::MASK_OFS, 32'h1 << sdsp_pkg::EV_WRITE_BIT);
        fork
            host.send(32'h3c5a_96e1);
            wait_on(2, 1'b1, 400);
        join
        chk(wr_word, 32'h3c5a_96e1);
        chk({31'h0, host_err}, 32'h0);
        repeat (2) @(posedge clk);
        chk({31'h0, irq}, 32'h1);
        reg_rd(sdsp_pkg::WRWORD_OFS, v);
        chk(v, 32'h3c5a_96e1);
        reg_wr(sdsp_pkg::MASK_OFS, 32'h0);
        @(posedge clk);
        chk({31'h0, irq}, 32'h0);
        reg_wr(sdsp_pkg::STATUS_OFS, 32'hf);
        reg_wr(sdsp_pkg::MASK_OFS, 32'h1 << sdsp_pkg::EV_WRITE_BIT);
        @(posedge clk);
        chk({31'h0, irq}, 32'h0);
        reg_rd(8'h20, v);
        chk(v, 32'h0);
        $display("write test done");
        // sync pulse just after a frame, held past four cycles
        wait_on(0, 1'b0, 600);
        wait_on(0, 1'b1, 200);
        sync_n <= 1'b0;
        wait_on(3, 1'b1, 8);
        @(posedge clk);
        sync_n <= 1'b1;
        // overrange follows its input one cycle later and flags its rise
        ovr_lvl <= 1'b1;
        repeat (2) @(posedge clk);
        chk({31'h0, ovr}, 32'h1);
        reg_rd(sdsp_pkg::STATUS_OFS, v);
        chk({30'h0, v[sdsp_pkg::EV_OVR_BIT], v[sdsp_pkg::EV_SYNC_BIT]}, 32'h3);
        reg_rd(sdsp_pkg::STATE_OFS, v);
        chk(v, {19'h0, 1'b1, 9'h080, 1'b0, sdsp_pkg::DEC_128});
        ovr_lvl <= 1'b0;
        repeat (2) @(posedge clk);
        chk({31'h0, ovr}, 32'h0);
        // low power halves the serial clock
        reg_wr(sdsp_pkg::CTRL_OFS, 32'h1);
        repeat (8) @(posedge clk);
        wait_on(1, 1'b0, 8);
        wait_on(1, 1'b1, 8);
        t0 = $time;
        wait_on(1, 1'b0, 8);
        chk(32'($time - t0), 32'h14);
        $display("sync and power mode test done");
        // power-down pin raises the flag and clears the control register
        pd_n <= 1'b0;
        repeat (6) @(posedge clk);
        chk({31'h0, pdown}, 32'h1);
        pd_n <= 1'b1;
        repeat (4) @(posedge clk);
        reg_rd(sdsp_pkg::CTRL_OFS, v);
        chk(v, 32'h0);
        $display("power-down test done");
        tally_and_finish();
    end
endmodule
